/* dv/bank_checker.sv */
// Purpose: port timing checks of the bank
// Assumes: one clock, sync reset
// Notes: bind after endmodule
`timescale 1ns/1ps
module bank_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic edge_pin_0,
	input wire logic edge_pin_1,
	input wire logic power_good_in,
	input wire logic platform_power_good,
	input wire logic [7:0] kbd_scan_code,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// quiet pins, so no edge can beat the clear
	sequence s_quiet;
		($stable(edge_pin_0) && $stable(edge_pin_1)) [*5];
	endsequence
	sequence s_clr;
		reg_wr && reg_addr == 8'h17 && reg_wdata == 8'h03;
	endsequence
	property p_kbd_wr;
		reg_wr && reg_addr == 8'h11 |=> kbd_scan_code == $past(reg_wdata);
	endproperty
	a_kbd_wr: assert property (p_kbd_wr) else $error("scan write lost");
	property p_kbd_rd;
		reg_rd && reg_addr == 8'h11 |=> reg_rdata == $past(kbd_scan_code);
	endproperty
	a_kbd_rd: assert property (p_kbd_rd) else $error("scan read wrong");
	property p_sts_zero;
		reg_rd && reg_addr == 8'h17 |=> reg_rdata[7:2] == 6'h00;
	endproperty
	a_sts_zero: assert property (p_sts_zero) else $error("status high bits");
	property p_ctl_zero;
		reg_rd && reg_addr == 8'h16 |=> !reg_rdata[0] && reg_rdata[6:4] == 3'h0;
	endproperty
	a_ctl_zero: assert property (p_ctl_zero) else $error("control reserved");
	property p_clr_irq;
		s_quiet ##0 s_clr |=> ##1 !irq;
	endproperty
	a_clr_irq: assert property (p_clr_irq) else $error("irq after clear");
	property p_clr_sts;
		s_quiet ##0 s_clr ##2 (reg_rd && reg_addr == 8'h17) |=> reg_rdata == 8'h00;
	endproperty
	a_clr_sts: assert property (p_clr_sts) else $error("status not cleared");
	property p_pg_fall;
		(!power_good_in) [*5] |-> !platform_power_good;
	endproperty
	a_pg_fall: assert property (p_pg_fall) else $error("good stuck high");
	property p_pg_rise;
		$rose(platform_power_good) |-> power_good_in && $past(power_good_in, 2);
	endproperty
	a_pg_rise: assert property (p_pg_rise) else $error("good rose early");
endmodule : bank_checker

bind runtime_misc_register_bank bank_checker chk_u (.core_clk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .edge_pin_0, .edge_pin_1, .power_good_in,
	.platform_power_good, .kbd_scan_code, .irq);

/* dv/board_pins_model.sv */
// Purpose: board side of the edge pins and power good
// Assumes: bench asks for levels
// Notes: pins move one edge after the bench asks
`timescale 1ns/1ps
module board_pins_model (
	input wire logic core_clk,
	input wire logic [2:0] want,
	output logic edge_pin_0,
	output logic edge_pin_1,
	output logic power_good_in
);
	initial {power_good_in, edge_pin_1, edge_pin_0} = 3'h0;
	always @(posedge core_clk) begin
		{power_good_in, edge_pin_1, edge_pin_0} <= want;
	end
endmodule : board_pins_model

/* dv/tb.sv */
// Purpose: directed bank tests
// Assumes: delay shortened to 16
// Notes: outputs sampled 1 ns after the edge
`timescale 1ns/1ps
module tb;
	import runtime_misc_pkg::*;
	logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, power_event_req = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0;
	logic [15:0] fan1_speed_reading = 0, fan2_speed_reading = 0;
	logic [2:0] want = 0;
	logic edge_pin_0, edge_pin_1, power_good_in, power_event_out_n_o;
	logic power_event_out_n_oe, platform_power_good, irq;
	reg_byte_t reg_rdata, kbd_scan_code;
	reg_byte_t rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h00};
	int n_fail = 0, n_compared = 0;
	always #4 core_clk = ~core_clk;
	runtime_misc_register_bank #(.DELAY_CYCLES(16)) dut_u (.core_clk, .reset, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fan1_speed_reading, .fan2_speed_reading,
		.edge_pin_0, .edge_pin_1, .power_event_req, .power_good_in, .power_event_out_n_o,
		.power_event_out_n_oe, .platform_power_good, .kbd_scan_code, .irq);
	board_pins_model pins_u (.core_clk, .want, .edge_pin_0, .edge_pin_1, .power_good_in);
	task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask : wr
	task automatic rc(string n, logic [7:0] a, logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 check(n, reg_rdata, exp);
	endtask : rc
	task automatic hold(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : hold
	task automatic print_verdict();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 0;
		for (int i = 0; i < 7; i++) rc("reset", 8'h11 + 8'(i), rst_tab[i]);
		$display("test reset done");
		wr(8'h11, 8'hA5);
		#1 check("scan port", kbd_scan_code, 8'hA5);
		rc("scan", 8'h11, 8'hA5);
		@(posedge core_clk);
		fan1_speed_reading <= 16'h12C3;
		fan2_speed_reading <= 16'hA55A;
		// read-only bytes ignore the write
		wr(8'h13, 8'hFF);
		rc("fan1 low", 8'h12, 8'hC3);
		rc("fan1 high", 8'h13, 8'h12);
		rc("fan2 low", 8'h14, 8'h5A);
		rc("fan2 high", 8'h15, 8'hA5);
		$display("test regs done");
		@(posedge core_clk);
		power_event_req <= 1;
		hold(3);
		check("oe open", power_event_out_n_oe, 1);
		check("o open", power_event_out_n_o, 0);
		wr(8'h16, 8'hF7);
		rc("control", 8'h16, 8'h86);
		check("oe invert", power_event_out_n_oe, 0);
		wr(8'h16, 8'h04);
		hold(2);
		check("o push", power_event_out_n_o, 0);
		check("oe push", power_event_out_n_oe, 1);
		@(posedge core_clk);
		power_event_req <= 0;
		hold(3);
		check("o push idle", power_event_out_n_o, 1);
		wr(8'h16, 8'h84);
		$display("test event done");
		@(posedge core_clk);
		want[2] <= 1;
		hold(12);
		check("good wait", platform_power_good, 0);
		hold(14);
		check("good late", platform_power_good, 1);
		@(posedge core_clk);
		want[2] <= 0;
		hold(6);
		check("good fall", platform_power_good, 0);
		wr(8'h16, 8'h08);
		rc("lock", 8'h16, 8'h08);
		wr(8'h16, 8'h04);
		rc("lock held", 8'h16, 8'h08);
		@(posedge core_clk);
		want[2] <= 1;
		hold(6);
		check("good plain", platform_power_good, 1);
		$display("test power done");
		wr(8'h1D, 8'h03);
		@(posedge core_clk);
		want[0] <= 1;
		hold(8);
		check("irq edge", irq, 1);
		wr(8'h17, 8'h02);
		rc("status0", 8'h17, 8'h01);
		wr(8'h17, 8'h01);
		rc("status clr", 8'h17, 8'h00);
		@(posedge core_clk);
		want[1:0] <= 2'b10;
		hold(8);
		rc("status both", 8'h17, 8'h03);
		wr(8'h1E, 8'h01);
		rc("status alias", 8'h17, 8'h02);
		rc("clear reads", 8'h1E, 8'h00);
		// masked flags keep the line low
		wr(8'h1D, 8'h00);
		hold(2);
		check("irq masked", irq, 0);
		wr(8'h17, 8'h03);
		rc("status none", 8'h17, 8'h00);
		$display("test edge done");
		print_verdict();
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		n_fail++;
		print_verdict();
	end
endmodule : tb

/* rtl/runtime_misc_cfg.svh */
// Purpose: offsets, field positions, reset values and timing of the runtime misc bank
// Assumes: byte-wide registers at their printed offsets
// Notes: included by bare name
`ifndef RUNTIME_MISC_CFG_SVH
`define RUNTIME_MISC_CFG_SVH

`define OFS_KBD_SCAN_CODE 8'h11
`define OFS_FAN1_SPEED_LOW 8'h12
`define OFS_FAN1_SPEED_HIGH 8'h13
`define OFS_FAN2_SPEED_LOW 8'h14
`define OFS_FAN2_SPEED_HIGH 8'h15
`define OFS_EVENT_OUTPUT_CONTROL 8'h16
`define OFS_MISC_EDGE_STATUS 8'h17
`define OFS_EVENT_IRQ_ENABLE 8'h1D
`define OFS_EVENT_IRQ_CLEAR 8'h1E

`define CTL_POLARITY_BIT 1
`define CTL_DELAY_SEL_BIT 2
`define CTL_LOCK_BIT 3
`define CTL_OPEN_DRAIN_BIT 7

`define RST_KBD_SCAN_CODE 8'h00
`define RST_FAN_SPEED 16'h0000
`define RST_EVENT_OUTPUT_CONTROL 8'h84
`define RST_MISC_EDGE_STATUS 2'h0
`define RST_EVENT_IRQ_ENABLE 2'h0

`define CORE_CLK_MHZ 125
`define PLATFORM_GOOD_DELAY_MS 100
`define PLATFORM_GOOD_DELAY_CYCLES (`PLATFORM_GOOD_DELAY_MS * 1000 * `CORE_CLK_MHZ)

`endif

/* rtl/runtime_misc_pkg.sv */
// Purpose: types shared by the runtime misc bank
// Assumes: nothing
// Notes: numbers live in runtime_misc_cfg.svh
package runtime_misc_pkg;

	typedef enum logic [1:0] {
		PG_LOW,
		PG_WAIT,
		PG_HIGH
	} platform_good_state_e;

	typedef logic [7:0] reg_byte_t;

endpackage : runtime_misc_pkg

/* rtl/runtime_misc_register_bank.sv */
// Purpose: runtime register slice 0x11..0x17, 0x1D and 0x1E with event output and edge status
// Assumes: fan readings and power_event_req come from logic on core_clk
// Notes: pins edge_pin_x and power_good_in are synchronised here
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "runtime_misc_cfg.svh"

module runtime_misc_register_bank
	import runtime_misc_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = `PLATFORM_GOOD_DELAY_CYCLES,
	parameter int unsigned EDGE_PINS = 2
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] fan1_speed_reading,
	input wire logic [15:0] fan2_speed_reading,
	input wire logic edge_pin_0,
	input wire logic edge_pin_1,
	input wire logic power_event_req,
	input wire logic power_good_in,
	output logic power_event_out_n_o,
	output logic power_event_out_n_oe,
	output logic platform_power_good,
	output logic [7:0] kbd_scan_code,
	output logic irq
);

	localparam int unsigned TIMER_W = (DELAY_CYCLES > 1) ? $clog2(DELAY_CYCLES) : 1;
	localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(DELAY_CYCLES - 1);
	localparam logic [7:0] CTL_RESET = `RST_EVENT_OUTPUT_CONTROL;

	typedef struct packed {
		logic [EDGE_PINS-1:0] edge_meta;
		logic [EDGE_PINS-1:0] edge_sync;
		logic [EDGE_PINS-1:0] edge_prev;
		logic edge_primed;
		logic pg_meta;
		logic pg_sync;
		reg_byte_t kbd;
		logic [15:0] fan1;
		logic [15:0] fan2;
		logic ctl_polarity;
		logic ctl_delay_sel;
		logic ctl_lock;
		logic ctl_open_drain;
		logic [EDGE_PINS-1:0] status;
		logic [EDGE_PINS-1:0] irq_enable;
		platform_good_state_e pg_state;
		logic [TIMER_W-1:0] pg_timer;
		logic pg_out;
		logic pin_out;
		logic pin_oe;
		logic irq;
		reg_byte_t rdata;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic [EDGE_PINS-1:0] edge_pins;
	logic [EDGE_PINS-1:0] edge_seen;
	logic [EDGE_PINS-1:0] clear_mask;
	logic wr_status;
	logic wr_irq_clear;
	logic wr_control;
	logic pin_level;
	reg_byte_t rd_mux;
	reg_byte_t ctl_view;

	assign edge_pins = {edge_pin_1, edge_pin_0};

	genvar gi;
	generate
		for (gi = 0; gi < EDGE_PINS; gi++) begin : g_edge
			// primed gate opens one cycle after reset, before edge_sync settles; a pin high at release still shows as an edge
			assign edge_seen[gi] = state_q.edge_primed &
				(state_q.edge_sync[gi] ^ state_q.edge_prev[gi]);
		end
	endgenerate

	assign wr_status = reg_wr && (reg_addr == `OFS_MISC_EDGE_STATUS);
	assign wr_irq_clear = reg_wr && (reg_addr == `OFS_EVENT_IRQ_CLEAR);
	assign wr_control = reg_wr && (reg_addr == `OFS_EVENT_OUTPUT_CONTROL);

	always_comb begin
		clear_mask = '0;
		if (wr_status) begin
			clear_mask = clear_mask | reg_wdata[EDGE_PINS-1:0];
		end
		if (wr_irq_clear) begin
			clear_mask = clear_mask | reg_wdata[EDGE_PINS-1:0];
		end
	end

	always_comb begin
		ctl_view = 8'h00;
		ctl_view[`CTL_POLARITY_BIT] = state_q.ctl_polarity;
		ctl_view[`CTL_DELAY_SEL_BIT] = state_q.ctl_delay_sel;
		ctl_view[`CTL_LOCK_BIT] = state_q.ctl_lock;
		ctl_view[`CTL_OPEN_DRAIN_BIT] = state_q.ctl_open_drain;
	end

	// unmapped offsets answer zero
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == `OFS_KBD_SCAN_CODE) begin
			rd_mux = state_q.kbd;
		end else if (reg_addr == `OFS_FAN1_SPEED_LOW) begin
			rd_mux = state_q.fan1[7:0];
		end else if (reg_addr == `OFS_FAN1_SPEED_HIGH) begin
			rd_mux = state_q.fan1[15:8];
		end else if (reg_addr == `OFS_FAN2_SPEED_LOW) begin
			rd_mux = state_q.fan2[7:0];
		end else if (reg_addr == `OFS_FAN2_SPEED_HIGH) begin
			rd_mux = state_q.fan2[15:8];
		end else if (reg_addr == `OFS_EVENT_OUTPUT_CONTROL) begin
			rd_mux = ctl_view;
		end else if (reg_addr == `OFS_MISC_EDGE_STATUS) begin
			rd_mux = {{(8 - EDGE_PINS){1'b0}}, state_q.status};
		end else if (reg_addr == `OFS_EVENT_IRQ_ENABLE) begin
			rd_mux = {{(8 - EDGE_PINS){1'b0}}, state_q.irq_enable};
		end
	end

	assign pin_level = state_q.ctl_polarity ? power_event_req : ~power_event_req;

	always_comb begin
		state_d = state_q;

		// two flops before any logic reads the pins
		state_d.edge_meta = edge_pins;
		state_d.edge_sync = state_q.edge_meta;
		state_d.edge_prev = state_q.edge_sync;
		state_d.edge_primed = 1'b1;
		state_d.pg_meta = power_good_in;
		state_d.pg_sync = state_q.pg_meta;

		if (reg_wr && (reg_addr == `OFS_KBD_SCAN_CODE)) begin
			state_d.kbd = reg_wdata;
		end

		// readings follow the measuring logic every cycle
		state_d.fan1 = fan1_speed_reading;
		state_d.fan2 = fan2_speed_reading;

		if (wr_control) begin
			state_d.ctl_polarity = reg_wdata[`CTL_POLARITY_BIT];
			state_d.ctl_open_drain = reg_wdata[`CTL_OPEN_DRAIN_BIT];
			if (!state_q.ctl_lock) begin
				state_d.ctl_delay_sel = reg_wdata[`CTL_DELAY_SEL_BIT];
				state_d.ctl_lock = reg_wdata[`CTL_LOCK_BIT];
			end
		end

		if (reg_wr && (reg_addr == `OFS_EVENT_IRQ_ENABLE)) begin
			state_d.irq_enable = reg_wdata[EDGE_PINS-1:0];
		end

		state_d.status = (state_q.status & ~clear_mask) | edge_seen;

		// rising power good waits while ctl_delay_sel is set, falling passes at once
		case (state_q.pg_state)
			PG_LOW: begin
				if (state_q.pg_sync) begin
					state_d.pg_state = PG_WAIT;
					state_d.pg_timer = TIMER_LOAD;
				end
			end
			PG_WAIT: begin
				if (!state_q.pg_sync) begin
					state_d.pg_state = PG_LOW;
				end else if (state_q.pg_timer == '0) begin
					state_d.pg_state = PG_HIGH;
				end else begin
					state_d.pg_timer = state_q.pg_timer - 1'b1;
				end
			end
			PG_HIGH: begin
				if (!state_q.pg_sync) begin
					state_d.pg_state = PG_LOW;
				end
			end
			default: begin
				state_d.pg_state = PG_LOW;
			end
		endcase

		if (state_q.ctl_delay_sel) begin
			state_d.pg_out = (state_q.pg_state == PG_HIGH) && state_q.pg_sync;
		end else begin
			state_d.pg_out = state_q.pg_sync;
		end

		if (state_q.ctl_open_drain) begin
			state_d.pin_out = 1'b0;
			state_d.pin_oe = ~pin_level;
		end else begin
			state_d.pin_out = pin_level;
			state_d.pin_oe = 1'b1;
		end

		// level interrupt, one cycle behind the status
		state_d.irq = |(state_q.status & state_q.irq_enable);

		// read data stands only the cycle after the strobe
		state_d.rdata = reg_rd ? rd_mux : 8'h00;

		if (reset) begin
			state_d = '0;
			state_d.pg_state = PG_LOW;
			state_d.kbd = `RST_KBD_SCAN_CODE;
			state_d.fan1 = `RST_FAN_SPEED;
			state_d.fan2 = `RST_FAN_SPEED;
			state_d.ctl_polarity = CTL_RESET[`CTL_POLARITY_BIT];
			state_d.ctl_delay_sel = CTL_RESET[`CTL_DELAY_SEL_BIT];
			state_d.ctl_lock = CTL_RESET[`CTL_LOCK_BIT];
			state_d.ctl_open_drain = CTL_RESET[`CTL_OPEN_DRAIN_BIT];
			state_d.status = `RST_MISC_EDGE_STATUS;
			state_d.irq_enable = `RST_EVENT_IRQ_ENABLE;
		end
	end

	always_ff @(posedge core_clk) begin
		state_q <= state_d;
	end

	assign reg_rdata = state_q.rdata;
	assign kbd_scan_code = state_q.kbd;
	assign platform_power_good = state_q.pg_out;
	assign power_event_out_n_o = state_q.pin_out;
	assign power_event_out_n_oe = state_q.pin_oe;
	assign irq = state_q.irq;

endmodule : runtime_misc_register_bank
